// ==== design/lpvc_defs.svh ====
/*
 * Offsets, field positions, reset values and widths of the low power
 * voltage control block.
 * Assumes inclusion by bare name from the package and from the design files.
 */
`ifndef LPVC_DEFS_SVH
`define LPVC_DEFS_SVH

// ****************************************************************
// Bus geometry
// ****************************************************************
`define LPVC_AXI_AW          8
`define LPVC_RESP_OKAY       2'h0
`define LPVC_RESP_SLVERR     2'h2

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define LPVC_OFF_CTRL        8'h00
`define LPVC_OFF_WAKE_FLAGS  8'h04
`define LPVC_OFF_WAKE_EN     8'h08
`define LPVC_OFF_IRQ_STAT    8'h10
`define LPVC_OFF_IRQ_MASK    8'h14
`define LPVC_OFF_MON_STAT    8'h18
`define LPVC_OFF_RAM_SD      8'h40

// ****************************************************************
// Control register fields
// ****************************************************************
`define LPVC_B_VDDIO_POR_DIS 25
`define LPVC_B_VCORE_SVM_DIS 20
`define LPVC_B_VCORE_POR_DIS 12
`define LPVC_B_BANDGAP_PD    11
`define LPVC_B_QUICK_WAKE    10
`define LPVC_B_RETREG_EN     8
`define LPVC_B_DET_BYPASS    6
`define LPVC_B_VRANGE_HI     5
`define LPVC_B_VRANGE_LO     4
`define LPVC_B_RAMRET_HI     3
`define LPVC_B_RAMRET_LO     0
`define LPVC_RST_VCORE_POR_DIS 1'b1
`define LPVC_RST_BANDGAP_PD  1'b1
`define LPVC_RST_RETREG_EN   1'b1
`define LPVC_VRANGE_RSVD     2'h3

// ****************************************************************
// Widths and interrupt status bits
// ****************************************************************
`define LPVC_WAKE_W          14
`define LPVC_RAM_BANKS       4
`define LPVC_IRQ_W           4
`define LPVC_IRQ_CORE        0
`define LPVC_IRQ_IO          1
`define LPVC_IRQ_PFAIL       2
`define LPVC_IRQ_WAKE        3

`endif

// ==== design/lpvc_pkg.sv ====
/*
 * Types of the low power voltage control block: bus carriers,
 * configuration, outputs and module state.
 * Assumes lpvc_defs.svh on the include path.
 */
`include "lpvc_defs.svh"

package lpvc_pkg;

	typedef logic [`LPVC_AXI_AW-1:0] lpvc_addr_t;

	// Core voltage and internal clock pairs; code 3 is never stored
	typedef enum logic [1:0] {
		LPVC_V0P9_24M = 2'h0,
		LPVC_V1P0_48M = 2'h1,
		LPVC_V1P1_96M = 2'h2
	} lpvc_vrange_e;

	typedef struct packed {
		logic       awvalid;
		lpvc_addr_t awaddr;
		logic       wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bready;
		logic       arvalid;
		lpvc_addr_t araddr;
		logic       rready;
	} lpvc_axil_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} lpvc_axil_rsp_s;

	typedef struct packed {
		logic        valid;
		lpvc_addr_t  addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} lpvc_wr_s;

	typedef struct packed {
		lpvc_axil_rsp_s rsp;
		lpvc_addr_t     awaddr;
		logic [31:0]    wdata;
		logic [3:0]     wstrb;
		logic           aw_full;
		logic           w_full;
	} lpvc_axs_state_s;

	typedef struct packed {
		logic                       vddio_por_dis;
		logic                       vcore_svm_dis;
		logic                       vcore_por_dis;
		logic                       bandgap_sleep_power_down;
		logic                       quick_wake_select;
		logic                       retreg_en;
		logic                       det_bypass;
		lpvc_vrange_e               vrange;
		logic [`LPVC_RAM_BANKS-1:0] ramret;
	} lpvc_ctrl_s;

	typedef struct packed {
		logic                       core_domain_reset;
		logic                       io_domain_reset;
		logic                       device_por;
		logic                       core_por_gated;
		logic                       bandgap_off;
		logic                       ro_warmup_skip;
		logic                       short_warmup;
		logic                       retention_reg_on;
		logic                       vdd_retention_on;
		logic                       ext_detect_bypass;
		lpvc_vrange_e               core_vrange;
		logic [`LPVC_RAM_BANKS-1:0] ram_retain;
		logic [`LPVC_RAM_BANKS-1:0] ram_shutdown;
	} lpvc_out_s;

	typedef struct packed {
		lpvc_ctrl_s                 ctrl;
		logic [`LPVC_WAKE_W-1:0]    wake_flags;
		logic [`LPVC_WAKE_W-1:0]    wake_en;
		logic [`LPVC_RAM_BANKS-1:0] ram_sd;
		logic [`LPVC_IRQ_W-1:0]     irq_stat;
		logic [`LPVC_IRQ_W-1:0]     irq_mask;
		lpvc_out_s                  pwr;
		logic                       irq;
	} lpvc_state_s;

endpackage

// ==== design/lpvc_axil_slave.sv ====
/*
 * AXI4-Lite slave front end: takes write address and data in either
 * order, hands one write at a time to the register file, answers reads
 * one cycle after the address is taken.
 * Assumes the register file decodes addresses and applies the write
 * pulse on the same edge that raises bvalid.
 */
`timescale 1ns/1ns
`default_nettype none
`include "lpvc_defs.svh"

module lpvc_axil_slave (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire lpvc_pkg::lpvc_axil_req_s axi_req,
	output wire lpvc_pkg::lpvc_axil_rsp_s axi_rsp,
	output var  lpvc_pkg::lpvc_wr_s      wr,
	input  wire logic                    wr_hit,
	output wire lpvc_pkg::lpvc_addr_t    rd_addr,
	input  wire logic [31:0]             rd_data,
	input  wire logic                    rd_hit
);

	localparam lpvc_pkg::lpvc_axs_state_s RST = '{
		rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
		default: '0
	};

	lpvc_pkg::lpvc_axs_state_s q;
	lpvc_pkg::lpvc_axs_state_s next_q;

	assign axi_rsp = q.rsp;
	assign rd_addr = axi_req.araddr;

	always_comb begin
		next_q = q;
		wr = '{valid: 1'b0, addr: q.awaddr, data: q.wdata, strb: q.wstrb};
		if (axi_req.awvalid && q.rsp.awready) begin
			next_q.awaddr      = axi_req.awaddr;
			next_q.aw_full     = 1'b1;
			next_q.rsp.awready = 1'b0;
		end
		if (axi_req.wvalid && q.rsp.wready) begin
			next_q.wdata      = axi_req.wdata;
			next_q.wstrb      = axi_req.wstrb;
			next_q.w_full     = 1'b1;
			next_q.rsp.wready = 1'b0;
		end
		// Only one write outstanding: wait for the response to drain
		if (q.aw_full && q.w_full && !q.rsp.bvalid) begin
			wr.valid           = wr_hit;
			next_q.rsp.bvalid  = 1'b1;
			next_q.rsp.bresp   = wr_hit ? `LPVC_RESP_OKAY : `LPVC_RESP_SLVERR;
			next_q.aw_full     = 1'b0;
			next_q.w_full      = 1'b0;
			next_q.rsp.awready = 1'b1;
			next_q.rsp.wready  = 1'b1;
		end
		if (q.rsp.bvalid && axi_req.bready) begin
			next_q.rsp.bvalid = 1'b0;
		end
		if (axi_req.arvalid && q.rsp.arready) begin
			next_q.rsp.rvalid  = 1'b1;
			next_q.rsp.arready = 1'b0;
			next_q.rsp.rdata   = rd_hit ? rd_data : 32'h0000_0000;
			next_q.rsp.rresp   = rd_hit ? `LPVC_RESP_OKAY : `LPVC_RESP_SLVERR;
		end
		if (q.rsp.rvalid && axi_req.rready) begin
			next_q.rsp.rvalid  = 1'b0;
			next_q.rsp.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST;
		end else begin
			q <= next_q;
		end
	end

endmodule

`default_nettype wire

// ==== design/lpvc_top.sv ====
/*
 * Low power voltage control: supply monitor gating, domain resets,
 * power fail warning interrupt, deep low power and backup state controls,
 * core voltage range and RAM bank retention and shutdown selection.
 * Assumes supply monitor trips and state indications arrive synchronous
 * to aclk; a reset here stands for the power-on reset of the block.
 */
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "lpvc_defs.svh"

module lpvc_top (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire lpvc_pkg::lpvc_axil_req_s     axi_req,
	output wire lpvc_pkg::lpvc_axil_rsp_s     axi_rsp,
	input  wire logic                         vcore_svm_trip,
	input  wire logic                         vddio_por_trip,
	input  wire logic                         vcore_pfail_trip,
	input  wire logic                         core_por_req,
	input  wire logic                         deep_low_power_state,
	input  wire logic                         backup_state,
	input  wire logic [`LPVC_WAKE_W-1:0]      gpio_wake_event,
	output wire lpvc_pkg::lpvc_out_s          pwr,
	output wire logic                         irq
);

	// ****************************************************************
	// Reset state
	// ****************************************************************
	localparam lpvc_pkg::lpvc_ctrl_s CTRL_RST = '{
		vcore_por_dis: `LPVC_RST_VCORE_POR_DIS,
		bandgap_sleep_power_down: `LPVC_RST_BANDGAP_PD,
		retreg_en: `LPVC_RST_RETREG_EN,
		vrange: lpvc_pkg::LPVC_V1P1_96M,
		default: '0
	};
	localparam lpvc_pkg::lpvc_state_s RST = '{
		ctrl: CTRL_RST,
		pwr: '{core_vrange: lpvc_pkg::LPVC_V1P1_96M, default: '0},
		default: '0
	};

	lpvc_pkg::lpvc_state_s q;
	lpvc_pkg::lpvc_state_s next_q;
	lpvc_pkg::lpvc_wr_s    wr;
	lpvc_pkg::lpvc_addr_t  rd_addr;
	logic [31:0]           rd_data;
	logic                  rd_hit;
	logic                  wr_hit;

	assign pwr = q.pwr;
	assign irq = q.irq;

	// ****************************************************************
	// Register access helpers
	// ****************************************************************
	function automatic logic hit(input lpvc_pkg::lpvc_addr_t a);
		logic h;
		unique case (a)
			`LPVC_OFF_CTRL, `LPVC_OFF_WAKE_FLAGS, `LPVC_OFF_WAKE_EN,
			`LPVC_OFF_IRQ_STAT, `LPVC_OFF_IRQ_MASK, `LPVC_OFF_MON_STAT,
			`LPVC_OFF_RAM_SD: h = 1'b1;
			default: h = 1'b0;
		endcase
		return h;
	endfunction

	// Reserved bits read as zero
	function automatic logic [31:0] ctrl_word(input lpvc_pkg::lpvc_ctrl_s c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`LPVC_B_VDDIO_POR_DIS] = c.vddio_por_dis;
		w[`LPVC_B_VCORE_SVM_DIS] = c.vcore_svm_dis;
		w[`LPVC_B_VCORE_POR_DIS] = c.vcore_por_dis;
		w[`LPVC_B_BANDGAP_PD] = c.bandgap_sleep_power_down;
		w[`LPVC_B_QUICK_WAKE] = c.quick_wake_select;
		w[`LPVC_B_RETREG_EN] = c.retreg_en;
		w[`LPVC_B_DET_BYPASS] = c.det_bypass;
		w[`LPVC_B_VRANGE_HI:`LPVC_B_VRANGE_LO] = c.vrange;
		w[`LPVC_B_RAMRET_HI:`LPVC_B_RAMRET_LO] = c.ramret;
		return w;
	endfunction

	function automatic logic [31:0] rd_reg(input lpvc_pkg::lpvc_addr_t a,
			input lpvc_pkg::lpvc_state_s s);
		logic [31:0] w;
		w = 32'h0000_0000;
		unique case (a)
			`LPVC_OFF_CTRL: w = ctrl_word(s.ctrl);
			`LPVC_OFF_WAKE_FLAGS: w[`LPVC_WAKE_W-1:0] = s.wake_flags;
			`LPVC_OFF_WAKE_EN: w[`LPVC_WAKE_W-1:0] = s.wake_en;
			`LPVC_OFF_IRQ_STAT: w[`LPVC_IRQ_W-1:0] = s.irq_stat;
			`LPVC_OFF_IRQ_MASK: w[`LPVC_IRQ_W-1:0] = s.irq_mask;
			`LPVC_OFF_MON_STAT: begin
				w[`LPVC_IRQ_CORE] = s.pwr.core_domain_reset;
				w[`LPVC_IRQ_IO] = s.pwr.io_domain_reset;
				w[`LPVC_IRQ_PFAIL] = s.pwr.device_por;
			end
			`LPVC_OFF_RAM_SD: w[`LPVC_RAM_BANKS-1:0] = s.ram_sd;
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction

	assign wr_hit  = hit(wr.addr);
	assign rd_hit  = hit(rd_addr);
	assign rd_data = rd_reg(rd_addr, q);

	lpvc_axil_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.axi_req (axi_req),
		.axi_rsp (axi_rsp),
		.wr      (wr),
		.wr_hit  (wr_hit),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_hit  (rd_hit)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	logic [31:0]            wmask;
	logic [31:0]            merged;
	logic [31:0]            w1c;
	logic [`LPVC_IRQ_W-1:0] evt;
	logic                   sleep_any;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{wr.strb[gi]}};
		end
	endgenerate

	assign merged    = (rd_reg(wr.addr, q) & ~wmask) | (wr.data & wmask);
	assign w1c       = wr.data & wmask;
	assign sleep_any = deep_low_power_state || backup_state;

	always_comb begin
		next_q = q;
		if (wr.valid) begin
			unique case (wr.addr)
				`LPVC_OFF_CTRL: begin
					next_q.ctrl.vddio_por_dis = merged[`LPVC_B_VDDIO_POR_DIS];
					next_q.ctrl.vcore_svm_dis = merged[`LPVC_B_VCORE_SVM_DIS];
					next_q.ctrl.vcore_por_dis = merged[`LPVC_B_VCORE_POR_DIS];
					next_q.ctrl.bandgap_sleep_power_down = merged[`LPVC_B_BANDGAP_PD];
					next_q.ctrl.quick_wake_select = merged[`LPVC_B_QUICK_WAKE];
					next_q.ctrl.retreg_en = merged[`LPVC_B_RETREG_EN];
					next_q.ctrl.det_bypass = merged[`LPVC_B_DET_BYPASS];
					next_q.ctrl.ramret = merged[`LPVC_B_RAMRET_HI:`LPVC_B_RAMRET_LO];
					// Reserved range code would leave the regulator undefined
					if (merged[`LPVC_B_VRANGE_HI:`LPVC_B_VRANGE_LO] != `LPVC_VRANGE_RSVD) begin
						next_q.ctrl.vrange = lpvc_pkg::lpvc_vrange_e'(
							merged[`LPVC_B_VRANGE_HI:`LPVC_B_VRANGE_LO]);
					end
				end
				`LPVC_OFF_WAKE_FLAGS: next_q.wake_flags = q.wake_flags & ~w1c[`LPVC_WAKE_W-1:0];
				`LPVC_OFF_WAKE_EN: next_q.wake_en = merged[`LPVC_WAKE_W-1:0];
				`LPVC_OFF_IRQ_STAT: next_q.irq_stat = q.irq_stat & ~w1c[`LPVC_IRQ_W-1:0];
				`LPVC_OFF_IRQ_MASK: next_q.irq_mask = merged[`LPVC_IRQ_W-1:0];
				`LPVC_OFF_RAM_SD: next_q.ram_sd = merged[`LPVC_RAM_BANKS-1:0];
				default: next_q.ram_sd = q.ram_sd;
			endcase
		end
		// Events are applied after the clear, so a set in the same cycle wins
		evt = '0;
		evt[`LPVC_IRQ_CORE] = vcore_svm_trip && !q.ctrl.vcore_svm_dis;
		evt[`LPVC_IRQ_IO] = vddio_por_trip && !q.ctrl.vddio_por_dis;
		evt[`LPVC_IRQ_PFAIL] = vcore_pfail_trip && !q.ctrl.vcore_svm_dis;
		evt[`LPVC_IRQ_WAKE] = |(gpio_wake_event & q.wake_en);
		next_q.irq_stat = next_q.irq_stat | evt;
		next_q.wake_flags = next_q.wake_flags | gpio_wake_event;
		next_q.irq = |(next_q.irq_stat & next_q.irq_mask);

		// Monitor actions use the current enables
		next_q.pwr.core_domain_reset = evt[`LPVC_IRQ_CORE];
		next_q.pwr.io_domain_reset = evt[`LPVC_IRQ_IO];
		next_q.pwr.device_por = evt[`LPVC_IRQ_PFAIL];
		// Configuration outputs follow the newly written value, one cycle on
		next_q.pwr.core_por_gated = core_por_req
			&& !(next_q.ctrl.vcore_por_dis && sleep_any);
		next_q.pwr.bandgap_off = next_q.ctrl.bandgap_sleep_power_down && sleep_any;
		next_q.pwr.ro_warmup_skip = next_q.ctrl.quick_wake_select;
		next_q.pwr.short_warmup = next_q.ctrl.quick_wake_select;
		next_q.pwr.retention_reg_on = next_q.ctrl.retreg_en && backup_state;
		next_q.pwr.vdd_retention_on = !next_q.ctrl.retreg_en && backup_state;
		next_q.pwr.ext_detect_bypass = next_q.ctrl.det_bypass;
		next_q.pwr.core_vrange = next_q.ctrl.vrange;
		next_q.pwr.ram_retain = next_q.ctrl.ramret;
		next_q.pwr.ram_shutdown = next_q.ram_sd;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [1:0] wr_vrange;
	logic       ctrl_wr;
	assign wr_vrange = wr.data[`LPVC_B_VRANGE_HI:`LPVC_B_VRANGE_LO];
	assign ctrl_wr   = wr.valid && (wr.addr == `LPVC_OFF_CTRL) && wr.strb[0];

	sequence s_core_trip;
		vcore_svm_trip && !q.ctrl.vcore_svm_dis && q.irq_mask[`LPVC_IRQ_CORE];
	endsequence

	sequence s_range_write;
		ctrl_wr && (wr_vrange != `LPVC_VRANGE_RSVD);
	endsequence

	a_core_dom_reset: assert property (vcore_svm_trip |=>
		pwr.core_domain_reset == !$past(q.ctrl.vcore_svm_dis))
		else $error("core domain reset does not follow monitor trip");
	a_io_dom_reset: assert property (vddio_por_trip |=>
		pwr.io_domain_reset == !$past(q.ctrl.vddio_por_dis))
		else $error("io domain reset does not follow monitor trip");
	a_device_por: assert property ((vcore_pfail_trip && !q.ctrl.vcore_svm_dis) |=>
		pwr.device_por)
		else $error("power fail did not force device reset");
	a_warn_irq_raise: assert property (s_core_trip |=> irq && q.irq_stat[`LPVC_IRQ_CORE])
		else $error("monitor trip did not raise interrupt");
	a_por_gating: assert property ((core_por_req && sleep_any) |=>
		pwr.core_por_gated == !q.ctrl.vcore_por_dis)
		else $error("core reset gating wrong in sleep state");
	a_bandgap_sleep: assert property (!sleep_any |=> !pwr.bandgap_off)
		else $error("bandgap powered down outside sleep states");
	a_quick_wake: assert property (pwr.ro_warmup_skip == q.ctrl.quick_wake_select
		&& pwr.short_warmup == pwr.ro_warmup_skip)
		else $error("quick wake outputs disagree with control");
	a_retention_src: assert property (backup_state |=>
		pwr.retention_reg_on == q.ctrl.retreg_en && pwr.vdd_retention_on == !q.ctrl.retreg_en)
		else $error("retention source wrong in backup state");
	a_det_bypass: assert property (pwr.ext_detect_bypass == q.ctrl.det_bypass)
		else $error("supply detection bypass not applied");
	a_range_legal: assert property (pwr.core_vrange != `LPVC_VRANGE_RSVD)
		else $error("reserved voltage range reached output");
	a_ram_retain: assert property (pwr.ram_retain == q.ctrl.ramret)
		else $error("RAM retention select not applied");
	a_range_apply: assert property (s_range_write |=>
		q.ctrl.vrange == $past(wr_vrange) ##0 pwr.core_vrange == $past(wr_vrange))
		else $error("range write not applied on next cycle");
	a_range_rsvd: assert property ((ctrl_wr && wr_vrange == `LPVC_VRANGE_RSVD) |=>
		$stable(q.ctrl.vrange))
		else $error("reserved range write changed the range");

	// ****************************************************************
	// Supply monitor checks
	// ****************************************************************
	// Release checks catch a domain reset stuck after its trip
	sequence s_io_trip;
		vddio_por_trip && !q.ctrl.vddio_por_dis;
	endsequence

	sequence s_pfail_trip;
		vcore_pfail_trip && !q.ctrl.vcore_svm_dis;
	endsequence

	a_core_dom_clear: assert property (!vcore_svm_trip |=>
		!pwr.core_domain_reset)
		else $error("core domain reset stuck");
	a_io_dom_clear: assert property (!vddio_por_trip |=>
		!pwr.io_domain_reset)
		else $error("io domain reset stuck");
	a_core_svm_off: assert property ((vcore_svm_trip && q.ctrl.vcore_svm_dis) |=>
		!pwr.core_domain_reset)
		else $error("disabled core monitor reset");
	a_io_por_off: assert property ((vddio_por_trip && q.ctrl.vddio_por_dis) |=>
		!pwr.io_domain_reset)
		else $error("disabled io monitor reset");
	a_pfail_off: assert property ((vcore_pfail_trip && q.ctrl.vcore_svm_dis) |=>
		!pwr.device_por)
		else $error("disabled power fail reset");
	a_pfail_clear: assert property (!vcore_pfail_trip |=>
		!pwr.device_por)
		else $error("device reset stuck");
	a_io_irq_raise: assert property (s_io_trip |=>
		q.irq_stat[`LPVC_IRQ_IO])
		else $error("io trip status not set");
	a_pfail_irq_raise: assert property (s_pfail_trip |=>
		q.irq_stat[`LPVC_IRQ_PFAIL])
		else $error("power fail status not set");
	a_core_stat_quiet: assert property ((!q.irq_stat[`LPVC_IRQ_CORE]
		&& !(vcore_svm_trip && !q.ctrl.vcore_svm_dis)) |=> !q.irq_stat[`LPVC_IRQ_CORE])
		else $error("core status set without trip");
	a_io_stat_quiet: assert property ((!q.irq_stat[`LPVC_IRQ_IO]
		&& !(vddio_por_trip && !q.ctrl.vddio_por_dis)) |=> !q.irq_stat[`LPVC_IRQ_IO])
		else $error("io status set without trip");

	// ****************************************************************
	// Configuration checks
	// ****************************************************************
	// Quick wake bit sits in byte lane one
	logic ctrl_wr_b1;
	assign ctrl_wr_b1 = wr.valid && (wr.addr == `LPVC_OFF_CTRL) && wr.strb[1];

	a_por_pass: assert property (!sleep_any |=>
		pwr.core_por_gated == $past(core_por_req))
		else $error("core reset blocked when awake");
	a_por_idle: assert property (!core_por_req |=>
		!pwr.core_por_gated)
		else $error("core reset without request");
	a_bandgap_on: assert property (sleep_any |=>
		pwr.bandgap_off == q.ctrl.bandgap_sleep_power_down)
		else $error("bandgap state wrong in sleep");
	a_retention_idle: assert property (!backup_state |=>
		!pwr.retention_reg_on && !pwr.vdd_retention_on)
		else $error("retention active outside backup");
	a_quick_apply: assert property (ctrl_wr_b1 |=>
		pwr.ro_warmup_skip == $past(wr.data[`LPVC_B_QUICK_WAKE]))
		else $error("quick wake write not applied");
	a_ram_ret_apply: assert property (ctrl_wr |=>
		pwr.ram_retain == $past(wr.data[`LPVC_B_RAMRET_HI:`LPVC_B_RAMRET_LO]))
		else $error("bank retention write not applied");
	a_range_hold: assert property (!ctrl_wr |=> $stable(q.ctrl.vrange))
		else $error("range changed without write");

endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
/*
 * Self-checking testbench of the low power voltage control block.
 * Assumes lpvc_pkg is compiled first and one 125 MHz clock drives everything.
 */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	typedef struct {
		string       nm;
		logic [33:0] ev;
	} lpvc_note_s;

	logic                     aclk;
	logic                     aresetn;
	lpvc_pkg::lpvc_axil_req_s rq;
	lpvc_pkg::lpvc_axil_rsp_s rsp;
	lpvc_pkg::lpvc_out_s      pwr;
	logic                     irq;
	logic                     svm, io, pf, por, deep, back;
	logic [13:0]              gwake;
	logic                     probe;
	logic [31:0]              seed;
	logic [31:0]              ctl;
	logic [31:0]              r;
	logic [3:0]               sd;
	logic [5:0]               in;
	lpvc_note_s               q[$];
	int                       n_errors;
	int                       checks_done;

	lpvc_top lpvc_top_i (
		.aclk                 (aclk),
		.aresetn              (aresetn),
		.axi_req              (rq),
		.axi_rsp              (rsp),
		.vcore_svm_trip       (svm),
		.vddio_por_trip       (io),
		.vcore_pfail_trip     (pf),
		.core_por_req         (por),
		.deep_low_power_state (deep),
		.backup_state         (back),
		.gpio_wake_event      (gwake),
		.pwr                  (pwr),
		.irq                  (irq)
	);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Input order {svm, io, pf, por, deep, back}
	function automatic lpvc_pkg::lpvc_out_s model(logic [31:0] c, logic [3:0] s, logic [5:0] i);
		lpvc_pkg::lpvc_out_s o;
		logic                slp;
		slp = i[1] | i[0];
		o.core_domain_reset = i[5] & ~c[20];
		o.io_domain_reset = i[4] & ~c[25];
		o.device_por = i[3] & ~c[20];
		o.core_por_gated = i[2] & ~(c[12] & slp);
		o.bandgap_off = c[11] & slp;
		o.ro_warmup_skip = c[10];
		o.short_warmup = c[10];
		o.retention_reg_on = c[8] & i[0];
		o.vdd_retention_on = ~c[8] & i[0];
		o.ext_detect_bypass = c[6];
		o.core_vrange = lpvc_pkg::lpvc_vrange_e'(c[5:4]);
		o.ram_retain = c[3:0];
		o.ram_shutdown = s;
		return o;
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic timeout(input string nm);
		n_errors++;
		$display("MISMATCH %s expected answer seen none", nm);
		results();
	endtask

	task automatic chk(input logic [33:0] g);
		lpvc_note_s n;
		checks_done++;
		if (q.size() == 0) begin
			n_errors++;
			$display("MISMATCH unexpected result expected none seen %h", g);
		end else begin
			n = q.pop_front();
			if (g !== n.ev) begin
				n_errors++;
				$display("MISMATCH %s expected %h seen %h", n.nm, n.ev, g);
			end
		end
	endtask

	// ****************************************************************
	// Watcher: pairs every result with the oldest note
	// ****************************************************************
	always @(posedge aclk) begin
		if (rsp.rvalid && rq.rready)
			chk({rsp.rresp, rsp.rdata});
		if (rsp.bvalid && rq.bready)
			chk({rsp.bresp, 32'h0});
		if (probe)
			chk({13'h0, pwr, irq});
	end

	// ****************************************************************
	// Drivers
	// ****************************************************************
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		q.push_back('{"write response", {er, 32'h0}});
		rq <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d, wstrb: 4'hf,
			bready: 1'b1, default: '0};
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (rsp.awready)
				rq.awvalid <= 1'b0;
			if (rsp.wready)
				rq.wvalid <= 1'b0;
			if (rsp.bvalid)
				break;
		end
		rq.bready <= 1'b0;
		if (n == 50)
			timeout("write response");
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		q.push_back('{"read data", {er, d}});
		rq <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (rsp.arready)
				rq.arvalid <= 1'b0;
			if (rsp.rvalid)
				break;
		end
		rq.rready <= 1'b0;
		if (n == 50)
			timeout("read data");
		@(posedge aclk);
	endtask

	task automatic setin(input logic [5:0] v);
		{svm, io, pf, por, deep, back} <= v;
	endtask

	task automatic pulse(input logic [5:0] v);
		setin(v);
		@(posedge aclk);
		setin(6'h0);
	endtask

	// Two edges: one for the input, one for the output flop
	task automatic look(input string nm, input lpvc_pkg::lpvc_out_s e, input logic ei);
		repeat (2) @(posedge aclk);
		q.push_back('{nm, {13'h0, e, ei}});
		probe <= 1'b1;
		@(posedge aclk);
		probe <= 1'b0;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		seed = 32'd4578;
		n_errors = 0;
		checks_done = 0;
		aresetn = 1'b0;
		rq = '0;
		{svm, io, pf, por, deep, back} = 6'h0;
		gwake = 14'h0;
		probe = 1'b0;
		sd = 4'h0;
		ctl = 32'h00001920;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h00, 32'h00001920, 2'h0);
		look("power outputs", model(32'h00001920, 4'h0, 6'h0), 1'b0);
		rd(8'h40, 32'h0, 2'h0);
		$display("test reset values finished");

		for (int k = 0; k < 16; k++) begin
			r = rnd();
			ctl = r & 32'h02101d7f;
			if (ctl[5:4] == 2'h3)
				ctl[5:4] = 2'h1;
			r = rnd();
			sd = r[3:0];
			in = r[9:4];
			wr(8'h00, ctl, 2'h0);
			wr(8'h40, {28'h0, sd}, 2'h0);
			setin(in);
			look("power outputs", model(ctl, sd, in), 1'b0);
			rd(8'h18, {29'h0, {in[3], in[4], in[5]} & ~{ctl[20], ctl[25], ctl[20]}}, 2'h0);
			rd(8'h00, ctl, 2'h0);
		end
		setin(6'h0);
		$display("test random configurations finished");

		// Range code 3 must keep the previous range
		wr(8'h00, 32'hffffffff, 2'h0);
		rd(8'h00, 32'h02101d4f | (ctl & 32'h30), 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h24, 32'h0000ffff, 2'h2);
		$display("test reserved and unmapped finished");

		wr(8'h00, 32'h00001920, 2'h0);
		wr(8'h10, 32'hf, 2'h0);
		rd(8'h10, 32'h0, 2'h0);
		wr(8'h14, 32'h1, 2'h0);
		pulse(6'h10);
		look("masked event", model(32'h00001920, sd, 6'h0), 1'b0);
		rd(8'h10, 32'h2, 2'h0);
		pulse(6'h28);
		look("unmasked event", model(32'h00001920, sd, 6'h0), 1'b1);
		rd(8'h10, 32'h7, 2'h0);
		wr(8'h10, 32'h1, 2'h0);
		look("cleared event", model(32'h00001920, sd, 6'h0), 1'b0);
		wr(8'h00, 32'h02101920, 2'h0);
		wr(8'h10, 32'hf, 2'h0);
		pulse(6'h38);
		rd(8'h10, 32'h0, 2'h0);
		wr(8'h08, 32'h5, 2'h0);
		gwake <= 14'h3;
		@(posedge aclk);
		gwake <= 14'h0;
		rd(8'h04, 32'h3, 2'h0);
		rd(8'h10, 32'h8, 2'h0);
		wr(8'h14, 32'h8, 2'h0);
		look("wake event", model(32'h02101920, sd, 6'h0), 1'b1);
		$display("test interrupts finished");
		results();
	end
endmodule

`default_nettype wire
